// ### scp_pkg.sv
package scp_pkg;

	// ----------------------------------------------------------------
	// widths
	// ----------------------------------------------------------------
	localparam int PC_W    = 12;
	localparam int INSTR_W = 18;
	localparam int DATA_W  = 8;
	localparam int OP_W    = 6;
	localparam int SEL_W   = 8;
	localparam int REG_AW  = 4;
	localparam int BANKS   = 2;

	// ----------------------------------------------------------------
	// parameter defaults
	// ----------------------------------------------------------------
	localparam logic [PC_W-1:0]   INT_VECTOR_DEF   = 12'h3FF;
	localparam logic [DATA_W-1:0] HW_BUILD_DEF     = 8'h00; // arbitrary
	localparam int                SCRATCH_SIZE_DEF = 64;
	localparam int                STACK_DEPTH_DEF  = 8;

	// ----------------------------------------------------------------
	// instruction fields
	// ----------------------------------------------------------------
	localparam int OP_MSB   = 17;
	localparam int OP_LSB   = 12;
	localparam int SX_MSB   = 11;
	localparam int SX_LSB   = 8;
	localparam int SY_MSB   = 7;
	localparam int SY_LSB   = 4;
	localparam int KK_MSB   = 7;
	localparam int KK_LSB   = 0;
	localparam int KOUT_MSB = 11;
	localparam int KOUT_LSB = 4;
	localparam int KP_MSB   = 3;
	localparam int KP_LSB   = 0;
	localparam int FLAG_BIT = 0;

	// ----------------------------------------------------------------
	// stack word fields
	// ----------------------------------------------------------------
	localparam int STK_BANK   = 0;
	localparam int STK_CARRY  = 1;
	localparam int STK_ZERO   = 2;
	localparam int STK_PC_LSB = 3;

	// ----------------------------------------------------------------
	// opcodes
	// ----------------------------------------------------------------
	localparam logic [OP_W-1:0] OP_LOAD_K  = 6'h01;
	localparam logic [OP_W-1:0] OP_ADD_K   = 6'h11;
	localparam logic [OP_W-1:0] OP_HWBUILD = 6'h14;
	localparam logic [OP_W-1:0] OP_INPUT   = 6'h09;
	localparam logic [OP_W-1:0] OP_FETCH   = 6'h0B;
	localparam logic [OP_W-1:0] OP_OUTPUT  = 6'h2D;
	localparam logic [OP_W-1:0] OP_OUTK    = 6'h2B;
	localparam logic [OP_W-1:0] OP_STORE   = 6'h2F;
	localparam logic [OP_W-1:0] OP_JUMP    = 6'h22;
	localparam logic [OP_W-1:0] OP_CALL    = 6'h20;
	localparam logic [OP_W-1:0] OP_RETURN  = 6'h25;
	localparam logic [OP_W-1:0] OP_RETI    = 6'h29;
	localparam logic [OP_W-1:0] OP_INTEN   = 6'h28;
	localparam logic [OP_W-1:0] OP_REGBANK = 6'h37;

	// ----------------------------------------------------------------
	// sequencer states, gray along reset -> fetch -> execute
	// ----------------------------------------------------------------
	typedef enum logic [1:0] {
		ST_RST   = 2'h0,
		ST_FETCH = 2'h1,
		ST_EXEC  = 2'h3
	} scp_state_t;

endpackage

// ### scp_core.sv
`timescale 1ns/10ps

module scp_core #(
	parameter logic [scp_pkg::PC_W-1:0]   INT_VECTOR   =
		scp_pkg::INT_VECTOR_DEF,
	parameter logic [scp_pkg::DATA_W-1:0] HW_BUILD     =
		scp_pkg::HW_BUILD_DEF,
	parameter int                         SCRATCH_SIZE =
		scp_pkg::SCRATCH_SIZE_DEF,
	parameter int                         STACK_DEPTH  =
		scp_pkg::STACK_DEPTH_DEF
) (
	input  wire logic                          sys_clk_i,
	input  wire logic                          rstn_i,
	output logic      [scp_pkg::PC_W-1:0]      address_o,
	input  wire logic [scp_pkg::INSTR_W-1:0]   instruction_i,
	output logic                               bram_enable_o,
	output logic      [scp_pkg::SEL_W-1:0]     port_select_o,
	output logic      [scp_pkg::DATA_W-1:0]    out_data_o,
	output logic                               write_strobe_o,
	output logic                               k_write_strobe_o,
	output logic                               read_strobe_o,
	input  wire logic [scp_pkg::DATA_W-1:0]    in_data_i,
	input  wire logic                          interrupt_i,
	output logic                               interrupt_ack_o
);
	import scp_pkg::*;

	localparam int RAM_AW = $clog2(SCRATCH_SIZE);
	localparam int SP_W   = $clog2(STACK_DEPTH);
	localparam int RF_N   = BANKS * (1 << REG_AW);
	localparam int STK_W  = PC_W + STK_PC_LSB;

	// ----------------------------------------------------------------
	// power-up reset and storage
	// ----------------------------------------------------------------
	logic                por_q = 1'b1;
	logic                int_rst;
	logic [DATA_W-1:0]   regs_q [RF_N] = '{default: '0};
	logic [DATA_W-1:0]   ram_q [SCRATCH_SIZE] = '{default: '0};
	logic [STK_W-1:0]    stack_q [STACK_DEPTH];

	// ----------------------------------------------------------------
	// sequencer state
	// ----------------------------------------------------------------
	scp_state_t          st_q, st_d;
	logic [PC_W-1:0]     pc_q, pc_d;
	logic                bram_en_q, bram_en_d;
	logic [SEL_W-1:0]    sel_q, sel_d;
	logic [DATA_W-1:0]   out_q, out_d;
	logic                wr_stb_q, wr_stb_d;
	logic                k_stb_q, k_stb_d;
	logic                rd_stb_q, rd_stb_d;
	logic                ack_q, ack_d;
	logic                ie_q, ie_d;
	logic                bank_q, bank_d;
	logic                zero_q, zero_d;
	logic                carry_q, carry_d;
	logic [SP_W-1:0]     sp_q, sp_d;
	logic [REG_AW:0]     rd_dst_q, rd_dst_d;

	// ----------------------------------------------------------------
	// decode helpers and write ports
	// ----------------------------------------------------------------
	logic [OP_W-1:0]     op;
	logic [REG_AW:0]     sx_idx;
	logic [REG_AW:0]     sy_idx;
	logic [DATA_W-1:0]   sx_val;
	logic [DATA_W-1:0]   sy_val;
	logic [DATA_W-1:0]   kk;
	logic [SEL_W-1:0]    kport;
	logic [RAM_AW-1:0]   ram_a;
	logic [DATA_W:0]     sum;
	logic [SP_W-1:0]     sp_dec;
	logic [STK_W-1:0]    stk_top;
	logic                reg_we;
	logic [REG_AW:0]     reg_wa;
	logic [DATA_W-1:0]   reg_wd;
	logic                ram_we;
	logic                push;
	logic [STK_W-1:0]    push_val;

	assign int_rst = por_q | ~rstn_i;
	assign op      = instruction_i[OP_MSB:OP_LSB];
	assign sx_idx  = {bank_q, instruction_i[SX_MSB:SX_LSB]};
	assign sy_idx  = {bank_q, instruction_i[SY_MSB:SY_LSB]};
	assign sx_val  = regs_q[sx_idx];
	assign sy_val  = regs_q[sy_idx];
	assign kk      = instruction_i[KK_MSB:KK_LSB];
	assign kport   = SEL_W'(instruction_i[KP_MSB:KP_LSB]);
	assign ram_a   = sy_val[RAM_AW-1:0];
	assign sum     = {1'b0, sx_val} + {1'b0, kk};
	assign sp_dec  = sp_q - 1'b1;
	assign stk_top = stack_q[sp_dec];

	// ----------------------------------------------------------------
	// next-state logic
	// ----------------------------------------------------------------
	always_comb begin
		st_d     = st_q;
		pc_d     = pc_q;
		bram_en_d = 1'b0;
		sel_d    = sel_q;
		out_d    = out_q;
		wr_stb_d = 1'b0;
		k_stb_d  = 1'b0;
		rd_stb_d = 1'b0;
		ack_d    = 1'b0;
		ie_d     = ie_q;
		bank_d   = bank_q;
		zero_d   = zero_q;
		carry_d  = carry_q;
		sp_d     = sp_q;
		rd_dst_d = rd_dst_q;
		reg_we   = 1'b0;
		reg_wa   = sx_idx;
		reg_wd   = kk;
		ram_we   = 1'b0;
		push     = 1'b0;
		push_val = {pc_q + 1'b1, zero_q, carry_q, bank_q};
		if (int_rst) begin
			st_d    = ST_RST;
			pc_d    = '0;
			bank_d  = 1'b0;
			ie_d    = 1'b0;
			zero_d  = 1'b0;
			carry_d = 1'b0;
			sp_d    = '0;
		end else begin
			case (st_q)
				ST_RST: begin
					st_d      = ST_FETCH;
					bram_en_d = 1'b1;
				end
				ST_FETCH: begin
					st_d = ST_EXEC;
					if (rd_stb_q) begin
						reg_we = 1'b1;
						reg_wa = rd_dst_q;
						reg_wd = in_data_i;
					end
				end
				ST_EXEC: begin
					st_d      = ST_FETCH;
					bram_en_d = 1'b1;
					pc_d      = pc_q + 1'b1;
					if (ie_q && interrupt_i) begin
						push     = 1'b1;
						push_val = {pc_q, zero_q, carry_q, bank_q};
						pc_d     = INT_VECTOR;
						ie_d     = 1'b0;
						ack_d    = 1'b1;
					end else begin
						case (op)
							OP_LOAD_K: begin
								reg_we = 1'b1;
							end
							OP_ADD_K: begin
								reg_we  = 1'b1;
								reg_wd  = sum[DATA_W-1:0];
								carry_d = sum[DATA_W];
								zero_d  = (sum[DATA_W-1:0] == '0);
							end
							OP_HWBUILD: begin
								reg_we = 1'b1;
								reg_wd = HW_BUILD;
							end
							OP_FETCH: begin
								reg_we = 1'b1;
								reg_wd = ram_q[ram_a];
							end
							OP_STORE: begin
								ram_we = 1'b1;
							end
							OP_INPUT: begin
								sel_d    = kk;
								rd_stb_d = 1'b1;
								rd_dst_d = sx_idx;
							end
							OP_OUTPUT: begin
								sel_d    = kk;
								out_d    = sx_val;
								wr_stb_d = 1'b1;
							end
							OP_OUTK: begin
								sel_d   = kport;
								out_d   = instruction_i[KOUT_MSB:KOUT_LSB];
								k_stb_d = 1'b1;
							end
							OP_JUMP: begin
								pc_d = instruction_i[PC_W-1:0];
							end
							OP_CALL: begin
								push = 1'b1;
								pc_d = instruction_i[PC_W-1:0];
							end
							OP_RETURN: begin
								sp_d = sp_dec;
								pc_d = stk_top[STK_W-1:STK_PC_LSB];
							end
							OP_RETI: begin
								sp_d    = sp_dec;
								pc_d    = stk_top[STK_W-1:STK_PC_LSB];
								zero_d  = stk_top[STK_ZERO];
								carry_d = stk_top[STK_CARRY];
								bank_d  = stk_top[STK_BANK];
								ie_d    = instruction_i[FLAG_BIT];
							end
							OP_INTEN: begin
								ie_d = instruction_i[FLAG_BIT];
							end
							OP_REGBANK: begin
								bank_d = instruction_i[FLAG_BIT];
							end
							default: begin
								pc_d = pc_q + 1'b1;
							end
						endcase
					end
					if (push) begin
						sp_d = sp_q + 1'b1;
					end
				end
				default: begin
					st_d = ST_RST;
				end
			endcase
		end
	end

	// ----------------------------------------------------------------
	// registers; storage is not cleared by reset
	// ----------------------------------------------------------------
	always_ff @(posedge sys_clk_i) begin
		por_q     <= 1'b0;
		st_q      <= st_d;
		pc_q      <= pc_d;
		bram_en_q <= bram_en_d;
		sel_q     <= sel_d;
		out_q     <= out_d;
		wr_stb_q  <= wr_stb_d;
		k_stb_q   <= k_stb_d;
		rd_stb_q  <= rd_stb_d;
		ack_q     <= ack_d;
		ie_q      <= ie_d;
		bank_q    <= bank_d;
		zero_q    <= zero_d;
		carry_q   <= carry_d;
		sp_q      <= sp_d;
		rd_dst_q  <= rd_dst_d;
	end

	always_ff @(posedge sys_clk_i) begin
		if (reg_we) begin
			regs_q[reg_wa] <= reg_wd;
		end
		if (ram_we) begin
			ram_q[ram_a] <= sx_val;
		end
		if (push) begin
			stack_q[sp_q] <= push_val;
		end
	end

	// ----------------------------------------------------------------
	// outputs
	// ----------------------------------------------------------------
	assign address_o        = pc_q;
	assign bram_enable_o    = bram_en_q;
	assign port_select_o    = sel_q;
	assign out_data_o       = out_q;
	assign write_strobe_o   = wr_stb_q;
	assign k_write_strobe_o = k_stb_q;
	assign read_strobe_o    = rd_stb_q;
	assign interrupt_ack_o  = ack_q;

endmodule

// ### scp_core_assertions.sv
`timescale 1ns/10ps

// ----------------------------------------------------------------
// port and reset checks
// ----------------------------------------------------------------
module scp_core_assertions
	import scp_pkg::*;
#(
	parameter logic [scp_pkg::PC_W-1:0] INT_VECTOR = scp_pkg::INT_VECTOR_DEF
) (
	input wire logic                        sys_clk_i,
	input wire logic                        rstn_i,
	input wire logic [scp_pkg::PC_W-1:0]    address_o,
	input wire logic [scp_pkg::INSTR_W-1:0] instruction_i,
	input wire logic                        bram_enable_o,
	input wire logic [scp_pkg::SEL_W-1:0]   port_select_o,
	input wire logic [scp_pkg::DATA_W-1:0]  out_data_o,
	input wire logic                        write_strobe_o,
	input wire logic                        k_write_strobe_o,
	input wire logic                        read_strobe_o,
	input wire logic [scp_pkg::DATA_W-1:0]  in_data_i,
	input wire logic                        interrupt_i,
	input wire logic                        interrupt_ack_o
);
	default clocking @(posedge sys_clk_i); endclocking
	default disable iff (!rstn_i);

	a_ack_pulse: assert property (
		interrupt_ack_o |=> !interrupt_ack_o) else $error("ack too long");
	a_ack_vector: assert property (
		interrupt_ack_o |-> address_o == INT_VECTOR && bram_enable_o)
		else $error("ack without vector fetch");
	a_wr_pulse: assert property (
		write_strobe_o |=> !write_strobe_o) else $error("write strobe long");
	a_kwr_port: assert property (
		k_write_strobe_o |-> port_select_o[7:4] == 4'h0 ##1 !k_write_strobe_o)
		else $error("constant write select or width wrong");
	a_rd_hold: assert property (
		read_strobe_o |=> $stable(port_select_o) && !read_strobe_o)
		else $error("read select not held");
	a_one_strobe: assert property (
		$onehot0({write_strobe_o, k_write_strobe_o, read_strobe_o,
		interrupt_ack_o})) else $error("strobes overlap");
	a_fetch_pace: assert property (
		bram_enable_o |=> !bram_enable_o && $stable(address_o)
		##1 bram_enable_o) else $error("fetch not every two cycles");
	a_rst_quiet: assert property (disable iff (1'b0)
		!rstn_i |=> address_o == 12'h000 && !bram_enable_o
		&& !write_strobe_o && !k_write_strobe_o && !read_strobe_o
		&& !interrupt_ack_o) else $error("activity during reset");
	a_start_zero: assert property (
		$rose(rstn_i) |-> ##[1:2] (bram_enable_o && address_o == 12'h000))
		else $error("no fetch from zero after reset");
endmodule

// ### scp_periph.sv
`timescale 1ns/10ps

// ----------------------------------------------------------------
// program memory and peripheral ports
// ----------------------------------------------------------------
module scp_periph
	import scp_pkg::*;
(
	input  wire logic                        sys_clk_i,
	input  wire logic [scp_pkg::PC_W-1:0]    address_i,
	input  wire logic                        bram_enable_i,
	output logic      [scp_pkg::INSTR_W-1:0] instruction_o,
	input  wire logic [scp_pkg::SEL_W-1:0]   port_select_i,
	input  wire logic [scp_pkg::DATA_W-1:0]  out_data_i,
	input  wire logic                        write_strobe_i,
	input  wire logic                        k_write_strobe_i,
	output logic      [scp_pkg::DATA_W-1:0]  in_data_o,
	input  wire logic                        raise_i,
	input  wire logic                        interrupt_ack_i,
	output logic                             interrupt_o
);
	logic [INSTR_W-1:0] rom [1024];
	logic [DATA_W-1:0]  wr_q [256];
	logic [DATA_W-1:0]  kp_q [16];

	initial begin
		instruction_o = '0;
		interrupt_o = 1'b0;
	end
	assign in_data_o = port_select_i ^ 8'h5A;
	always @(posedge sys_clk_i) begin
		if (bram_enable_i) begin
			instruction_o <= rom[address_i[9:0]];
		end
		if (write_strobe_i) begin
			wr_q[port_select_i] <= out_data_i;
		end
		if (k_write_strobe_i) begin
			kp_q[port_select_i[3:0]] <= out_data_i;
		end
		if (interrupt_ack_i) begin
			interrupt_o <= 1'b0;
		end else if (raise_i) begin
			interrupt_o <= 1'b1;
		end
	end
endmodule

// ### test_scp_core.sv
`timescale 1ns/10ps

// ----------------------------------------------------------------
// bench
// ----------------------------------------------------------------
module test_scp_core;
	import scp_pkg::*;
	localparam logic [DATA_W-1:0] HWB = 8'hC4;
	localparam logic [INSTR_W-1:0] PROG [12] = '{18'h0113C, 18'h2D1A5,
		18'h2B7E9, 18'h09233, 18'h2D2FF, 18'h14300, 18'h2D380,
		18'h2F13F, 18'h0B43F, 18'h2D481, 18'h28001, 18'h2200B};
	logic               sys_clk_i, rstn_i, raise, en, ws, kws, rs, irq, ack;
	logic [PC_W-1:0]    addr;
	logic [INSTR_W-1:0] instr;
	logic [SEL_W-1:0]   sel;
	logic [DATA_W-1:0]  odata, idata;
	int                 error_cnt, num_checks;

	scp_core #(.HW_BUILD(HWB)) u_dut (.sys_clk_i(sys_clk_i), .rstn_i(rstn_i),
		.address_o(addr), .instruction_i(instr), .bram_enable_o(en),
		.port_select_o(sel), .out_data_o(odata), .write_strobe_o(ws),
		.k_write_strobe_o(kws), .read_strobe_o(rs), .in_data_i(idata),
		.interrupt_i(irq), .interrupt_ack_o(ack));
	scp_periph u_per (.sys_clk_i(sys_clk_i), .address_i(addr),
		.bram_enable_i(en), .instruction_o(instr), .port_select_i(sel),
		.out_data_i(odata), .write_strobe_i(ws), .k_write_strobe_i(kws),
		.in_data_o(idata), .raise_i(raise), .interrupt_ack_i(ack),
		.interrupt_o(irq));

	task automatic chk(input logic [11:0] got, input logic [11:0] exp);
		num_checks++;
		if (got !== exp) begin
			error_cnt++;
			$display("ERROR %0t got %h exp %h", $time, got, exp);
		end
	endtask
	task automatic wait_en();
		int i;
		i = 0;
		do begin
			@(negedge sys_clk_i);
			i++;
		end while (!en && i < 8);
		chk({11'h000, en}, 12'h001);
	endtask
	task automatic t_fetch();
		for (int a = 0; a < 3; a++) begin
			wait_en();
			chk(addr, a[11:0]);
		end
	endtask
	task automatic t_ports();
		repeat (40) @(negedge sys_clk_i);
		chk({4'h0, u_per.wr_q[8'hA5]}, 12'h03C);
		chk({4'h0, u_per.kp_q[9]}, 12'h07E);
		chk({4'h0, u_per.wr_q[8'hFF]}, 12'h069);
		chk({4'h0, u_per.wr_q[8'h80]}, {4'h0, HWB});
		chk({4'h0, u_per.wr_q[8'h81]}, 12'h03C);
	endtask
	task automatic irq_ack();
		int i;
		@(posedge sys_clk_i) #1 raise = 1'b1;
		@(posedge sys_clk_i) #1 raise = 1'b0;
		i = 0;
		do begin
			@(negedge sys_clk_i);
			i++;
		end while (!ack && i < 10);
		chk({11'h000, ack}, 12'h001);
		chk(addr, INT_VECTOR_DEF);
		repeat (4) @(negedge sys_clk_i);
		chk({11'h000, irq}, 12'h000);
	endtask
	task automatic t_irq();
		irq_ack();
		chk({4'h0, u_per.kp_q[2]}, 12'h011);
	endtask
	task automatic t_sub();
		@(negedge sys_clk_i);
		u_per.rom[11] = 18'h20010;
		u_per.rom[12] = 18'h2D1C0;
		u_per.rom[13] = 18'h37001;
		u_per.rom[14] = 18'h2D1C1;
		u_per.rom[15] = 18'h2200F;
		u_per.rom[16] = 18'h11105;
		u_per.rom[17] = 18'h25000;
		u_per.rom[1023] = 18'h29001;
		repeat (50) @(negedge sys_clk_i);
		chk({4'h0, u_per.wr_q[8'hC0]}, 12'h041);
		chk({4'h0, u_per.wr_q[8'hC1]}, 12'h000);
		irq_ack();
		chk(addr, 12'h00F);
	endtask
	task automatic t_reset();
		@(posedge sys_clk_i) #1 rstn_i = 1'b0;
		repeat (3) @(posedge sys_clk_i);
		@(negedge sys_clk_i);
		chk(addr, 12'h000);
		chk({7'h00, en, ws, kws, rs, ack}, 12'h000);
		chk({11'h000, u_dut.bank_q}, 12'h000);
		chk({4'h0, u_dut.regs_q[4]}, 12'h03C);
		@(posedge sys_clk_i) #1 rstn_i = 1'b1;
		wait_en();
		chk(addr, 12'h000);
	endtask
	task automatic results();
		$display("checks %0d errors %0d", num_checks, error_cnt);
		if (error_cnt == 0 && num_checks > 0) begin
			$display("Result: passed");
		end else begin
			$display("Result: failed");
		end
		$finish;
	endtask

	initial begin
		sys_clk_i = 1'b0;
		forever #10 sys_clk_i = ~sys_clk_i;
	end
	initial begin
		#(400 * 20);
		error_cnt++;
		results();
	end
	initial begin
		rstn_i = 1'b0;
		raise = 1'b0;
		for (int i = 0; i < 1024; i++) u_per.rom[i] = 18'h00000;
		for (int i = 0; i < 12; i++) u_per.rom[i] = PROG[i];
		u_per.rom[1023] = 18'h2B112;
		repeat (3) @(posedge sys_clk_i);
		#1 rstn_i = 1'b1;
		t_fetch();
		t_ports();
		t_irq();
		t_sub();
		t_reset();
		results();
	end
endmodule

bind scp_core scp_core_assertions #(.INT_VECTOR(INT_VECTOR)) u_chk (
	.sys_clk_i(sys_clk_i), .rstn_i(rstn_i), .address_o(address_o),
	.instruction_i(instruction_i), .bram_enable_o(bram_enable_o),
	.port_select_o(port_select_o), .out_data_o(out_data_o),
	.write_strobe_o(write_strobe_o), .k_write_strobe_o(k_write_strobe_o),
	.read_strobe_o(read_strobe_o), .in_data_i(in_data_i),
	.interrupt_i(interrupt_i), .interrupt_ack_o(interrupt_ack_o));
